//--- pkg/rml_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef RML_REGS_VH
`define RML_REGS_VH
// Register byte offsets
`define RML_OFF_MODE 12'h000
`define RML_OFF_PLL 12'h004
`define RML_OFF_IRQCFG 12'h008
`define RML_OFF_STATUS 12'h00c
`define RML_OFF_MASK 12'h010
`define RML_OFF_STATE 12'h014
// Mode field: bit0 first pin, bit1 second pin, bit2 third pin
`define RML_MODE_W 3
// PLL control fields
`define RML_PLL_EN_BIT 0
// Interrupt config: edge select bits (1 = falling edge, 0 = low level)
`define RML_CFG_NMI_EDGE 0
`define RML_CFG_IRQ1_EDGE 1
`define RML_CFG_IRQ2_EDGE 2
// Status / mask bits
`define RML_ST_NMI 0
`define RML_ST_IRQ1 1
`define RML_ST_IRQ2 2
`define RML_ST_W 3
// State register bits
`define RML_SR_PINS_IRQ 0
`define RML_SR_LOCK 1
`define RML_SR_STOP 2
// Reset values
`define RML_RST_CFG 3'h0
`define RML_RST_MASK 3'h0
// Cycles after the mode latch, counted while the PLL is locked or disabled, before the mode pins become request inputs
`define RML_SWITCH_CYC 8
// Bus answers
`define RML_RESP_OKAY 2'h0
`define RML_RESP_SLVERR 2'h2
`endif

//--- verilog/rml_sync.v
// Two-flop synchroniser with falling edge and low-level detection
`timescale 1ns/10ps
`default_nettype none
module rml_sync (
    input wire i_clk, // Core clock
    input wire i_rstn, // Async reset, active low
    input wire i_pin, // Asynchronous request pin, active low
    input wire i_en, // Detection enabled
    input wire i_edge, // 1 falling edge, 0 low level
    output wire o_req // Request pulse or level
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    // Synchroniser chain; idle high
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= i_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // Edge or level request, only from synchronised stages
    assign o_req = i_en & (i_edge ? (s3_ff & ~s2_ff) : ~s2_ff);
endmodule // rml_sync
`default_nettype wire

//--- verilog/rml_top.v
// Reset mode latch, PLL init sample and external interrupt requests
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "rml_regs.vh"
module rml_top #(
    parameter SWITCH_CYC = `RML_SWITCH_CYC // Cycles until pins turn to IRQ
) (
    input wire i_clk, // Core clock 50 MHz
    input wire i_rstn, // Hardware reset, active low, async
    input wire i_mode_pin_first, // Mode pin 1 / first maskable request
    input wire i_mode_pin_second, // Mode pin 2 / second maskable request
    input wire i_mode_pin_third, // Mode pin 3 / NMI request
    input wire i_pll_initial_pin, // PLL initial enable pin
    input wire i_pll_locked, // PLL reports lock
    input wire i_stop, // Processor enters stop state (pulse)
    input wire [11:0] i_awaddr, // Write address
    input wire i_awvalid, // Write address valid
    output wire o_awready, // Write address ready
    input wire [31:0] i_wdata, // Write data
    input wire [3:0] i_wstrb, // Write strobes
    input wire i_wvalid, // Write data valid
    output wire o_wready, // Write data ready
    output reg [1:0] o_bresp, // Write response
    output reg o_bvalid, // Write response valid
    input wire i_bready, // Write response ready
    input wire [11:0] i_araddr, // Read address
    input wire i_arvalid, // Read address valid
    output wire o_arready, // Read address ready
    output reg [31:0] o_rdata, // Read data
    output reg [1:0] o_rresp, // Read response
    output reg o_rvalid, // Read data valid
    input wire i_rready, // Read data ready
    output wire o_core_rstn, // Internal reset, active low
    output wire [2:0] o_mode, // Operating mode
    output wire o_pll_enable_bit, // PLL enable
    output wire o_phase_lock_indicator, // PLL lock indicator pin
    output wire o_nmi, // Non-maskable interrupt request
    output wire o_irq, // Maskable interrupt level
    output wire o_stop // Processor held in stop state
);
    reg rs1_ff;
    reg rs2_ff;
    reg run_ff;
    reg [2:0] mode_ff;
    reg pen_ff;
    reg [15:0] cnt_ff;
    reg pins_irq_ff;
    reg [2:0] cfg_ff;
    reg [2:0] st_ff;
    reg [2:0] mask_ff;
    reg lock_ff;
    reg stop_ff;
    reg nmi_ff;
    reg aw_ff;
    reg w_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [2:0] nxt_st;
    reg [2:0] nxt_mode;
    reg [31:0] rd_val;
    reg rd_ok;
    wire nmi_req;
    wire irq1_req;
    wire irq2_req;
    wire wr_go;
    wire wr_ok;
    wire [2:0] w1c;
    wire [2:0] wr_mask;
    // Switch count widened to a fixed width so the cut to 16 bits is explicit
    localparam [31:0] SWITCH_W = SWITCH_CYC;

    // Reset release synchroniser, asserts async, deasserts on clock
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rs1_ff <= 1'b0;
            rs2_ff <= 1'b0;
        end
        else
        begin
            rs1_ff <= 1'b1;
            rs2_ff <= rs1_ff;
        end
    end
    assign o_core_rstn = rs2_ff;

    // Pin sample at first clock after internal reset release
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            run_ff <= 1'b0;
            mode_ff <= 3'h0;
            pen_ff <= 1'b0;
        end
        else if (rs2_ff && !run_ff)
        begin
            run_ff <= 1'b1;
            mode_ff <= {i_mode_pin_third, i_mode_pin_second,
                i_mode_pin_first};
            pen_ff <= i_pll_initial_pin;
        end
        else
        begin
            mode_ff <= nxt_mode;
            if (wr_ok && awaddr_ff == `RML_OFF_PLL && wstrb_ff[0])
                pen_ff <= wdata_ff[`RML_PLL_EN_BIT];
        end
    end

    // Count to the pin function switch, gated by PLL stabilisation
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_ff <= 16'h0000;
            pins_irq_ff <= 1'b0;
        end
        else if (run_ff && !pins_irq_ff && (i_pll_locked || !pen_ff))
        begin
            if (cnt_ff >= SWITCH_W[15:0] - 16'h0001)
                pins_irq_ff <= 1'b1;
            else
                cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    // Lock indicator low after reset until the enabled PLL locks
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            lock_ff <= 1'b0;
        else
            lock_ff <= run_ff & pen_ff & i_pll_locked;
    end
    assign o_phase_lock_indicator = lock_ff;

    // Synchronised request detectors
    rml_sync u_nmi (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin(i_mode_pin_third),
        .i_en(pins_irq_ff),
        .i_edge(cfg_ff[`RML_CFG_NMI_EDGE]),
        .o_req(nmi_req)
    );
    rml_sync u_irq1 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin(i_mode_pin_first),
        .i_en(pins_irq_ff),
        .i_edge(cfg_ff[`RML_CFG_IRQ1_EDGE]),
        .o_req(irq1_req)
    );
    rml_sync u_irq2 (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin(i_mode_pin_second),
        .i_en(pins_irq_ff),
        .i_edge(cfg_ff[`RML_CFG_IRQ2_EDGE]),
        .o_req(irq2_req)
    );

    // Write channel capture, address and data in either order
    assign o_awready = !aw_ff && !o_bvalid;
    assign o_wready = !w_ff && !o_bvalid;
    assign wr_go = aw_ff && w_ff && !o_bvalid;
    assign wr_ok = wr_go && (awaddr_ff == `RML_OFF_MODE ||
        awaddr_ff == `RML_OFF_PLL || awaddr_ff == `RML_OFF_IRQCFG ||
        awaddr_ff == `RML_OFF_STATUS || awaddr_ff == `RML_OFF_MASK);
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `RML_RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= {i_awaddr[11:2], 2'b00};
            end
            if (i_wvalid && o_wready)
            begin
                w_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_go)
            begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? `RML_RESP_OKAY : `RML_RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Software mode overwrite
    always @*
    begin
        nxt_mode = mode_ff;
        if (wr_ok && awaddr_ff == `RML_OFF_MODE && wstrb_ff[0])
            nxt_mode = wdata_ff[2:0];
    end

    // Sticky status, set wins over write-one-to-clear
    assign wr_mask = {3{wr_ok && wstrb_ff[0]}};
    assign w1c = (awaddr_ff == `RML_OFF_STATUS) ?
        (wdata_ff[2:0] & wr_mask) : 3'h0;
    always @*
    begin
        nxt_st = st_ff & ~w1c;
        if (nmi_req)
            nxt_st[`RML_ST_NMI] = 1'b1;
        if (irq1_req)
            nxt_st[`RML_ST_IRQ1] = 1'b1;
        if (irq2_req)
            nxt_st[`RML_ST_IRQ2] = 1'b1;
    end

    // Config, mask, status and stop state
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg_ff <= `RML_RST_CFG;
            mask_ff <= `RML_RST_MASK;
            st_ff <= 3'h0;
            stop_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            if (wr_ok && wstrb_ff[0] && awaddr_ff == `RML_OFF_IRQCFG)
                cfg_ff <= wdata_ff[2:0];
            if (wr_ok && wstrb_ff[0] && awaddr_ff == `RML_OFF_MASK)
                mask_ff <= wdata_ff[2:0];
            if (irq1_req)
                stop_ff <= 1'b0;
            else if (i_stop)
                stop_ff <= 1'b1;
            nmi_ff <= nxt_st[`RML_ST_NMI];
        end
    end
    assign o_nmi = nmi_ff;
    assign o_irq = |(st_ff & mask_ff & {2'b11, 1'b0});
    assign o_stop = stop_ff;
    assign o_mode = mode_ff;
    assign o_pll_enable_bit = pen_ff;

    // Read decode
    always @*
    begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        case ({i_araddr[11:2], 2'b00})
            `RML_OFF_MODE: rd_val = {29'h0, mode_ff};
            `RML_OFF_PLL: rd_val = {31'h0, pen_ff};
            `RML_OFF_IRQCFG: rd_val = {29'h0, cfg_ff};
            `RML_OFF_STATUS: rd_val = {29'h0, st_ff};
            `RML_OFF_MASK: rd_val = {29'h0, mask_ff};
            `RML_OFF_STATE: rd_val = {29'h0, stop_ff, lock_ff, pins_irq_ff};
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel
    assign o_arready = !o_rvalid;
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RML_RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_val;
            o_rresp <= rd_ok ? `RML_RESP_OKAY : `RML_RESP_SLVERR;
        end
        else if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
    end
endmodule // rml_top
`default_nettype wire

//--- tb/rml_top_checker.sv
// Assertions on the reset, mode latch and request ports
`timescale 1ns/10ps
`default_nettype none
module rml_top_checker (
    input wire logic i_clk, // Clock
    input wire logic i_rstn, // Reset
    input wire logic i_mode_pin_first, // Pin 1
    input wire logic i_mode_pin_second, // Pin 2
    input wire logic i_mode_pin_third, // Pin 3
    input wire logic i_pll_initial_pin, // PLL init
    input wire logic i_pll_locked, // Lock in
    input wire logic o_core_rstn, // Core reset
    input wire logic [2:0] o_mode, // Mode
    input wire logic o_pll_enable_bit, // PLL enable
    input wire logic o_phase_lock_indicator, // Lock pin
    input wire logic o_nmi, // NMI
    input wire logic o_stop, // Stop
    input wire logic o_bvalid // Write answer
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    property p_core;
        o_core_rstn |-> $past(i_rstn);
    endproperty
    a_core: assert property (p_core) else $error("early core reset");
    property p_mode;
        $rose(o_core_rstn) |=>
            o_mode == {i_mode_pin_third, i_mode_pin_second, i_mode_pin_first};
    endproperty
    a_mode: assert property (p_mode) else $error("mode not latched");
    property p_pen;
        $rose(o_core_rstn) |=> o_pll_enable_bit == i_pll_initial_pin;
    endproperty
    a_pen: assert property (p_pen) else $error("pll bit not loaded");
    property p_mwr;
        $changed(o_mode) && $past(o_core_rstn, 2) |-> $rose(o_bvalid);
    endproperty
    a_mwr: assert property (p_mwr) else $error("mode moved alone");
    property p_nsync;
        $rose(o_nmi) |-> !$past(i_mode_pin_third, 3);
    endproperty
    a_nsync: assert property (p_nsync) else $error("nmi not synced");
    property p_nhold;
        $fell(o_nmi) |-> $rose(o_bvalid);
    endproperty
    a_nhold: assert property (p_nhold) else $error("nmi dropped");
    property p_lock;
        o_phase_lock_indicator |-> $past(i_pll_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock pin early");
    property p_stop;
        $fell(o_stop) |-> !$past(i_mode_pin_first, 3);
    endproperty
    a_stop: assert property (p_stop) else $error("stop left alone");
    c_stop: cover property ($fell(o_stop));
    c_nmi: cover property ($rose(o_nmi));
    c_lock: cover property ($rose(o_phase_lock_indicator));
endmodule // rml_top_checker
bind rml_top rml_top_checker i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_mode_pin_first(i_mode_pin_first), .i_mode_pin_second(i_mode_pin_second),
    .i_mode_pin_third(i_mode_pin_third), .i_pll_initial_pin(i_pll_initial_pin),
    .i_pll_locked(i_pll_locked), .o_core_rstn(o_core_rstn), .o_mode(o_mode),
    .o_pll_enable_bit(o_pll_enable_bit), .o_nmi(o_nmi), .o_stop(o_stop),
    .o_phase_lock_indicator(o_phase_lock_indicator), .o_bvalid(o_bvalid));
`default_nettype wire

//--- tb/rml_board.sv
// Board model driving strap, request and PLL pins
`timescale 1ns/10ps
`default_nettype none
module rml_board #(
    parameter int LOCK_CYC = 30 // Cycles to lock
) (
    input wire logic i_clk, // Clock
    input wire logic i_rstn, // Reset
    input wire logic i_sel, // Pins carry requests
    input wire logic [2:0] i_req, // Requests
    input wire logic [2:0] i_mode, // Straps
    input wire logic i_pen, // PLL strap
    output logic o_mode_pin_first, // Pin 1
    output logic o_mode_pin_second, // Pin 2
    output logic o_mode_pin_third, // Pin 3
    output logic o_pll_initial_pin, // PLL init
    output logic o_pll_locked // Lock
);
    int cnt_ff;
    // Straps until told, then active-low requests
    assign {o_mode_pin_third, o_mode_pin_second, o_mode_pin_first} =
        i_sel ? ~i_req : i_mode;
    assign o_pll_initial_pin = i_pen;
    assign o_pll_locked = (cnt_ff == LOCK_CYC);
    // Lock arrives a while after reset exit
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_ff <= 0;
        else if (cnt_ff < LOCK_CYC)
            cnt_ff <= cnt_ff + 1;
    end
endmodule // rml_board
`default_nettype wire

//--- tb/rml_top_bench.sv
// Self-checking bench for the reset mode latch block
`timescale 1ns/10ps
`default_nettype none
module rml_top_bench;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic sel = 1'b0, pll_enable_bit = 1'b0, stop = 1'b0, awv = 1'b0, wv = 1'b0;
    logic br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [2:0] req = 3'h0, mode = 3'h0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0000_0000, rdata, d;
    logic [1:0] rresp, r, bresp, b;
    logic p1, p2, p3, pini, plk, core, penb, lock, nmi, irq, stp;
    logic awr, wrr, bv, arr, rv;
    logic [2:0] om;
    int failures = 0, check_count = 0;
    rml_board i_brd (.i_clk(i_clk), .i_rstn(i_rstn), .i_sel(sel),
        .i_req(req), .i_mode(mode), .i_pen(pll_enable_bit), .o_mode_pin_first(p1),
        .o_mode_pin_second(p2), .o_mode_pin_third(p3),
        .o_pll_initial_pin(pini), .o_pll_locked(plk));
    rml_top #(.SWITCH_CYC(2)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_mode_pin_first(p1), .i_mode_pin_second(p2), .i_mode_pin_third(p3),
        .i_pll_initial_pin(pini), .i_pll_locked(plk), .i_stop(stop),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
        .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr), .o_bresp(bresp),
        .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
        .i_rready(rr), .o_core_rstn(core), .o_mode(om),
        .o_pll_enable_bit(penb), .o_phase_lock_indicator(lock), .o_nmi(nmi),
        .o_irq(irq), .o_stop(stp));
    always #10 i_clk = ~i_clk;
    // Compare and count
    task chk(input string s, input logic [31:0] g, e);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    // Bus write, waits for the answer
    task wr(input logic [11:0] a, input logic [31:0] v);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (bv !== 1'b1);
        b = bresp;
        br <= 1'b0;
        @(posedge i_clk);
    endtask
    // Bus read
    task rd(input logic [11:0] a);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rdata;
        r = rresp;
        rr <= 1'b0;
        @(posedge i_clk);
    endtask
    // Reset with straps, then wait for the request function
    task rst(input logic [2:0] m, input logic p);
        i_rstn <= 1'b0;
        sel <= 1'b0;
        mode <= m;
        pll_enable_bit <= p;
        repeat (3) @(posedge i_clk);
        chk("core", core, 1'b0);
        chk("stop", stp, 1'b0);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk("core", core, 1'b1);
        chk("mode", om, m);
        chk("pen", penb, p);
        chk("lock", lock, 1'b0);
        sel <= 1'b1;
        repeat (40) @(posedge i_clk);
        chk("lock", lock, p);
        do
            rd(12'h014);
        while (d[0] !== 1'b1);
    endtask
    // Software mode rewrite and an unmapped read
    task t_mode;
        wr(12'h000, 32'h0000_0002);
        chk("bresp", b, 2'h0);
        rd(12'h000);
        chk("mode_reg", d, 32'h0000_0002);
        chk("mode", om, 3'h2);
        wr(12'h018, 32'h0000_0007);
        chk("bresp", b, 2'h2);
        chk("mode", om, 3'h2);
        rd(12'h018);
        chk("resp", r, 2'h2);
    endtask
    // NMI in level or edge mode, all masked
    task t_nmi(input logic e);
        wr(12'h008, {31'h0000_0000, e});
        wr(12'h010, 32'h0000_0000);
        req[2] <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("nmi", nmi, 1'b0);
        repeat (4) @(posedge i_clk);
        chk("nmi", nmi, 1'b1);
        wr(12'h00c, 32'h0000_0001);
        chk("nmi", nmi, !e);
        req[2] <= 1'b0;
        repeat (4) @(posedge i_clk);
        wr(12'h00c, 32'h0000_0001);
        chk("nmi", nmi, 1'b0);
    endtask
    // Stop exit and masking of the first request
    task t_irq;
        stop <= 1'b1;
        @(posedge i_clk);
        stop <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("stop", stp, 1'b1);
        req[0] <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk("stop", stp, 1'b0);
        chk("irq", irq, 1'b0);
        wr(12'h010, 32'h0000_0002);
        chk("irq", irq, 1'b1);
        req[0] <= 1'b0;
        repeat (4) @(posedge i_clk);
        wr(12'h00c, 32'h0000_0002);
        chk("irq", irq, 1'b0);
    endtask
    task finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        rst(3'h5, 1'b1);
        t_mode;
        t_nmi(1'b0);
        t_nmi(1'b1);
        t_irq;
        rst(3'h2, 1'b0);
        finish_test;
    end
    // Watchdog
    initial
    begin
        #100000;
        failures++;
        finish_test;
    end
endmodule // rml_top_bench
`default_nettype wire
